// >>> src/standard_timer_unit.sv
// Standard timer unit: 16-bit counter, compare A/P, output pin, Avalon-MM registers
//
// Overview of operation
// - Counter readable as low and high read-only bytes, reset to zero.
// - Compare A held in two read/write bytes, reset to zero.
// - Pause bit one halts counting; zero counts normally.
// - Pause keeps the count; resume continues from the kept value.
// - Three-bit field selects sys/4, sys, high/16, high/64, sub, pin edges.
// - Counter runs only while the on bit is one.
// - On bit rising clears the counter to zero.
// - On bit falling keeps the residual count.
// - On bit rising resets output pin to initial level in output modes.
// - Mode field: compare output, undefined, PWM/single pulse, timer.
// - Compare mode match A: none, low, high or toggle.
// - PWM mode pin function: inactive, active, PWM, single pulse.
// - Match requesting the present pin level shows no pin change.
// - Initial level bit sets compare start level or PWM active level.
// - Invert bit inverts the pin, except in timer mode.
// - Swap bit chooses which compare sets PWM period and duty.
// - Clear select: zero clears on P match, one on A match.
// - Control-zero bits 2 to 0 always read zero.
// - Timer mode drives no defined pin state; initial level unused.
// - Compare P matches counter high byte; compare A all sixteen bits.
// - Compare P of zero clears by overflow.
// - Low bytes pass a buffer; high byte access moves it.
`timescale 1ns/1ps

module standard_timer_unit (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Clock enables from other oscillators
  input  wire logic        high_clock_tick,
  input  wire logic        sub_clock_tick,
  // Pins
  input  wire logic        external_clock_pin,
  output logic             timer_output_pin,
  output logic             timer_output_used
);

  // ==========================================================
  // Registers
  standard_timer_pkg::control_zero_s ctrl0_ff;
  standard_timer_pkg::control_one_s  ctrl1_ff;
  logic [15:0] count_ff;
  logic [15:0] cmpa_ff;
  logic [7:0]  cmpp_ff;
  logic [7:0]  count_buf_ff;
  logic [7:0]  cmpa_buf_ff;
  logic        on_prev_ff;
  logic        ext_prev_ff;
  logic [1:0]  sys_div_ff;
  logic [5:0]  high_div_ff;
  logic        level_ff;
  logic        pulse_done_ff;
  logic [31:0] readdata_ff;
  logic        waitrequest_ff;
  logic        pin_ff;
  logic        used_ff;

  // ==========================================================
  // Bus decode
  logic access_done;
  logic wr_en;
  logic rd_grant;

  assign access_done = (read | write) & ~waitrequest_ff;
  assign wr_en       = write & ~waitrequest_ff & byteenable[0];
  assign rd_grant    = read & waitrequest_ff;

  function automatic logic hit(input logic [4:0] a, input logic [4:0] reg_addr);
    hit = (a == reg_addr);
  endfunction : hit

  // Waitrequest: low for one cycle after each request
  always_ff @(posedge clk) begin
    if (rst) begin
      waitrequest_ff <= 1'b1;
    end else if (access_done) begin
      waitrequest_ff <= 1'b1;
    end else if (read | write) begin
      waitrequest_ff <= 1'b0;
    end
  end

  // Read mux, loaded when the answer is granted
  logic [31:0] nxt_readdata;

  always_comb begin
    nxt_readdata = standard_timer_pkg::READ_ZERO;
    case (address)
      standard_timer_pkg::ADDR_CONTROL_ZERO: begin
        nxt_readdata[7:0] = {ctrl0_ff[7:3], standard_timer_pkg::CTRL0_UNUSED};
      end
      standard_timer_pkg::ADDR_CONTROL_ONE: begin
        nxt_readdata[7:0] = ctrl1_ff;
      end
      standard_timer_pkg::ADDR_COUNT_LOW: begin
        nxt_readdata[7:0] = count_buf_ff;
      end
      standard_timer_pkg::ADDR_COUNT_HIGH: begin
        nxt_readdata[7:0] = count_ff[15:8];
      end
      standard_timer_pkg::ADDR_CMPA_LOW: begin
        nxt_readdata[7:0] = cmpa_buf_ff;
      end
      standard_timer_pkg::ADDR_CMPA_HIGH: begin
        nxt_readdata[7:0] = cmpa_ff[15:8];
      end
      standard_timer_pkg::ADDR_CMPP: begin
        nxt_readdata[7:0] = cmpp_ff;
      end
      default: begin
        nxt_readdata = standard_timer_pkg::READ_ZERO;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      readdata_ff <= standard_timer_pkg::READ_ZERO;
    end else if (rd_grant) begin
      readdata_ff <= nxt_readdata;
    end
  end

  // ==========================================================
  // Control and compare registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl0_ff <= standard_timer_pkg::CTRL0_RESET;
      ctrl1_ff <= standard_timer_pkg::CTRL1_RESET;
      cmpp_ff  <= standard_timer_pkg::BYTE_RESET;
    end else if (wr_en) begin
      if (hit(address, standard_timer_pkg::ADDR_CONTROL_ZERO)) begin
        ctrl0_ff <= {writedata[7:3], standard_timer_pkg::CTRL0_UNUSED};
      end
      if (hit(address, standard_timer_pkg::ADDR_CONTROL_ONE)) begin
        ctrl1_ff <= writedata[7:0];
      end
      if (hit(address, standard_timer_pkg::ADDR_CMPP)) begin
        cmpp_ff <= writedata[7:0];
      end
    end
  end

  // Compare A pair with its low-byte buffer
  always_ff @(posedge clk) begin
    if (rst) begin
      cmpa_ff     <= standard_timer_pkg::COUNT_RESET;
      cmpa_buf_ff <= standard_timer_pkg::BYTE_RESET;
    end else begin
      if (wr_en && hit(address, standard_timer_pkg::ADDR_CMPA_LOW)) begin
        cmpa_buf_ff <= writedata[7:0];
      end else if (rd_grant && hit(address, standard_timer_pkg::ADDR_CMPA_HIGH)) begin
        cmpa_buf_ff <= cmpa_ff[7:0];
      end
      if (wr_en && hit(address, standard_timer_pkg::ADDR_CMPA_HIGH)) begin
        cmpa_ff <= {writedata[7:0], cmpa_buf_ff};
      end
    end
  end

  // Counter low-byte snapshot on high-byte read
  always_ff @(posedge clk) begin
    if (rst) begin
      count_buf_ff <= standard_timer_pkg::BYTE_RESET;
    end else if (rd_grant && hit(address, standard_timer_pkg::ADDR_COUNT_HIGH)) begin
      count_buf_ff <= count_ff[7:0];
    end
  end

  // ==========================================================
  // Clock source selection
  logic sys_div4_tick;
  logic high_d16_tick;
  logic high_d64_tick;
  logic ext_rise;
  logic ext_fall;
  logic count_tick;

  always_ff @(posedge clk) begin
    if (rst) begin
      sys_div_ff  <= 2'h0;
      high_div_ff <= standard_timer_pkg::DIV_ZERO;
      ext_prev_ff <= 1'b0;
    end else begin
      sys_div_ff  <= sys_div_ff + 2'h1;
      ext_prev_ff <= external_clock_pin;
      if (high_clock_tick) begin
        high_div_ff <= high_div_ff + 6'h01;
      end
    end
  end

  assign sys_div4_tick = (sys_div_ff == standard_timer_pkg::SYS_DIV4_LAST);
  assign high_d16_tick = high_clock_tick &&
                         ((high_div_ff & standard_timer_pkg::HIGH_DIV16_MSK) ==
                          standard_timer_pkg::HIGH_DIV16_MSK);
  assign high_d64_tick = high_clock_tick &&
                         (high_div_ff == standard_timer_pkg::HIGH_DIV64_MSK);
  assign ext_rise      = external_clock_pin & ~ext_prev_ff;
  assign ext_fall      = ~external_clock_pin & ext_prev_ff;

  // Sub clock answers to two codes; pin edges come from the previous-sample register
  always_comb begin
    case (ctrl0_ff.clock_source_select)
      standard_timer_pkg::CLK_SYS_DIV4: count_tick = sys_div4_tick;
      standard_timer_pkg::CLK_SYS:      count_tick = 1'b1;
      standard_timer_pkg::CLK_HIGH_D16: count_tick = high_d16_tick;
      standard_timer_pkg::CLK_HIGH_D64: count_tick = high_d64_tick;
      standard_timer_pkg::CLK_SUB_A:    count_tick = sub_clock_tick;
      standard_timer_pkg::CLK_SUB_B:    count_tick = sub_clock_tick;
      standard_timer_pkg::CLK_EXT_RISE: count_tick = ext_rise;
      standard_timer_pkg::CLK_EXT_FALL: count_tick = ext_fall;
      default:                          count_tick = 1'b0;
    endcase
  end

  // ==========================================================
  // Counter and comparators
  logic        on_rise;
  logic        running;
  logic [15:0] count_inc;
  logic        match_a;
  logic        match_p;
  logic        clear_hit;
  logic        pwm_mode;

  assign on_rise   = ctrl0_ff.module_on & ~on_prev_ff;
  // Compares look at count+1 so a clearing match replaces the increment on the same edge
  assign running   = ctrl0_ff.module_on & ~ctrl0_ff.pause_control & count_tick;
  assign count_inc = count_ff + standard_timer_pkg::COUNT_ONE;
  assign match_a   = (count_inc == cmpa_ff);
  assign match_p   = (count_inc == {cmpp_ff, standard_timer_pkg::LOW_BYTE_ZERO});
  assign pwm_mode  = (ctrl1_ff.operating_mode_select == standard_timer_pkg::MODE_PWM);

  always_comb begin
    if (pwm_mode) begin
      clear_hit = ctrl1_ff.duty_period_swap ? match_a : match_p;
    end else begin
      clear_hit = ctrl1_ff.clear_source_select ? match_a : match_p;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      on_prev_ff <= 1'b0;
    end else begin
      on_prev_ff <= ctrl0_ff.module_on;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_ff <= standard_timer_pkg::COUNT_RESET;
    end else if (on_rise) begin
      count_ff <= standard_timer_pkg::COUNT_RESET;
    end else if (running) begin
      if (clear_hit) begin
        count_ff <= standard_timer_pkg::COUNT_RESET;
      end else begin
        count_ff <= count_inc;
      end
    end
  end
  // Off or paused: count simply holds

  // ==========================================================
  // PWM duty and period, 17 bits so zero in compare P means 65536
  logic [16:0] duty_value;
  logic        pwm_active;

  always_comb begin
    if (ctrl1_ff.duty_period_swap) begin
      duty_value = (cmpp_ff == standard_timer_pkg::BYTE_RESET) ? 17'h10000 :
                   {1'b0, cmpp_ff, standard_timer_pkg::LOW_BYTE_ZERO};
    end else begin
      duty_value = {1'b0, cmpa_ff};
    end
  end

  assign pwm_active = ({1'b0, count_ff} < duty_value);

  // ==========================================================
  // Output level before inversion
  always_ff @(posedge clk) begin
    if (rst) begin
      level_ff      <= 1'b0;
      pulse_done_ff <= 1'b0;
    end else if (on_rise) begin
      level_ff      <= ctrl1_ff.output_initial_level;
      pulse_done_ff <= 1'b0;
    end else begin
      case (ctrl1_ff.operating_mode_select)
        standard_timer_pkg::MODE_COMPARE: begin
          if (running && match_a) begin
            case (ctrl1_ff.pin_function_select)
              standard_timer_pkg::PIN_FN_01: level_ff <= 1'b0;
              standard_timer_pkg::PIN_FN_10: level_ff <= 1'b1;
              standard_timer_pkg::PIN_FN_11: level_ff <= ~level_ff;
              default:                       level_ff <= level_ff;
            endcase
          end
        end
        standard_timer_pkg::MODE_PWM: begin
          case (ctrl1_ff.pin_function_select)
            standard_timer_pkg::PIN_FN_00: level_ff <= ~ctrl1_ff.output_initial_level;
            standard_timer_pkg::PIN_FN_01: level_ff <= ctrl1_ff.output_initial_level;
            standard_timer_pkg::PIN_FN_10: begin
              level_ff <= ctrl0_ff.module_on && pwm_active ?
                          ctrl1_ff.output_initial_level : ~ctrl1_ff.output_initial_level;
            end
            default: begin
              if (running && clear_hit) begin
                pulse_done_ff <= 1'b1;
              end
              level_ff <= ctrl0_ff.module_on && !pulse_done_ff && pwm_active ?
                          ctrl1_ff.output_initial_level : ~ctrl1_ff.output_initial_level;
            end
          endcase
        end
        default: begin
          level_ff <= level_ff;
        end
      endcase
    end
  end

  // ==========================================================
  // Pin drive, registered; timer mode leaves the pin unused
  logic timer_mode;

  assign timer_mode = (ctrl1_ff.operating_mode_select == standard_timer_pkg::MODE_TIMER);

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_ff  <= 1'b0;
      used_ff <= 1'b0;
    end else if (timer_mode) begin
      pin_ff  <= 1'b0;
      used_ff <= 1'b0;
    end else begin
      pin_ff  <= level_ff ^ ctrl1_ff.output_invert;
      used_ff <= 1'b1;
    end
  end

  assign readdata          = readdata_ff;
  assign waitrequest       = waitrequest_ff;
  assign timer_output_pin  = pin_ff;
  assign timer_output_used = used_ff;

endmodule : standard_timer_unit

// >>> src/standard_timer_pkg.sv
// Package: register map, field layouts and codes of the standard timer unit
package standard_timer_pkg;

  // ==========================================================
  // Register byte addresses on the Avalon-MM slave
  localparam logic [4:0] ADDR_CONTROL_ZERO = 5'h00;
  localparam logic [4:0] ADDR_CONTROL_ONE  = 5'h04;
  localparam logic [4:0] ADDR_COUNT_LOW    = 5'h08;
  localparam logic [4:0] ADDR_COUNT_HIGH   = 5'h0c;
  localparam logic [4:0] ADDR_CMPA_LOW     = 5'h10;
  localparam logic [4:0] ADDR_CMPA_HIGH    = 5'h14;
  localparam logic [4:0] ADDR_CMPP         = 5'h18;

  // ==========================================================
  // Widths, reset values and fixed patterns
  localparam int          COUNT_W        = 16;
  localparam logic [7:0]  BYTE_RESET     = 8'h00;
  localparam logic [15:0] COUNT_RESET    = 16'h0000;
  localparam logic [15:0] COUNT_ONE      = 16'h0001;
  localparam logic [7:0]  LOW_BYTE_ZERO  = 8'h00;
  localparam logic [2:0]  CTRL0_UNUSED   = 3'h0;
  localparam logic [31:0] READ_ZERO      = 32'h0000_0000;

  // ==========================================================
  // Clock dividers
  localparam logic [1:0]  SYS_DIV4_LAST  = 2'h3;
  localparam logic [5:0]  HIGH_DIV16_MSK = 6'h0f;
  localparam logic [5:0]  HIGH_DIV64_MSK = 6'h3f;
  localparam logic [5:0]  DIV_ZERO       = 6'h00;

  // ==========================================================
  // Encodings
  typedef enum logic [2:0] {
    CLK_SYS_DIV4  = 3'h0,
    CLK_SYS       = 3'h1,
    CLK_HIGH_D16  = 3'h2,
    CLK_HIGH_D64  = 3'h3,
    CLK_SUB_A     = 3'h4,
    CLK_SUB_B     = 3'h5,
    CLK_EXT_RISE  = 3'h6,
    CLK_EXT_FALL  = 3'h7
  } clock_source_e;

  typedef enum logic [1:0] {
    MODE_COMPARE  = 2'h0,
    MODE_UNDEF    = 2'h1,
    MODE_PWM      = 2'h2,
    MODE_TIMER    = 2'h3
  } operating_mode_e;

  typedef enum logic [1:0] {
    PIN_FN_00     = 2'h0,
    PIN_FN_01     = 2'h1,
    PIN_FN_10     = 2'h2,
    PIN_FN_11     = 2'h3
  } pin_function_e;

  // ==========================================================
  // Control register layouts
  typedef struct packed {
    logic          pause_control;
    clock_source_e clock_source_select;
    logic          module_on;
    logic [2:0]    unused;
  } control_zero_s;

  typedef struct packed {
    operating_mode_e operating_mode_select;
    pin_function_e   pin_function_select;
    logic            output_initial_level;
    logic            output_invert;
    logic            duty_period_swap;
    logic            clear_source_select;
  } control_one_s;

  localparam control_zero_s CTRL0_RESET = control_zero_s'(8'h00);
  localparam control_one_s  CTRL1_RESET = control_one_s'(8'h00);

endpackage : standard_timer_pkg

// >>> sim/timer_pins_model.sv
// Far-side model: external clock pin and oscillator tick sources
`timescale 1ns/1ps

module timer_pins_model (
  // Clock
  input  wire logic clk,
  // Far-side sources
  output logic      ext_pin,
  output logic      sub_tick,
  output logic      high_tick
);
  initial begin
    ext_pin   = 1'b0;
    sub_tick  = 1'b0;
    high_tick = 1'b0;
  end

  // Bursts of edges or ticks; the pin stands low between bursts
  task automatic pulse(input int sel, input int n);
    repeat (n) begin
      @(posedge clk);
      case (sel)
        0: ext_pin <= 1'b1;
        1: sub_tick <= 1'b1;
        default: high_tick <= 1'b1;
      endcase
      @(posedge clk);
      sub_tick  <= 1'b0;
      high_tick <= 1'b0;
      repeat (2) @(posedge clk);
      ext_pin <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask : pulse
endmodule : timer_pins_model

// >>> sim/timer_unit_asserts.sv
// Checker: bus handshake and output pin relations of the timer unit
`timescale 1ns/1ps

module timer_unit_asserts (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Register bus
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest,
  // Pin
  input  wire logic        timer_output_pin,
  input  wire logic        timer_output_used
);
  logic [7:0] c0_ff;
  logic [7:0] c1_ff;
  logic       take;

  // ==========================================================
  // Shadow copies of the control registers
  assign take = write && !waitrequest && byteenable[0];
  always_ff @(posedge clk) begin
    if (rst) begin
      c0_ff <= 8'h00;
      c1_ff <= 8'h00;
    end else if (take && address == standard_timer_pkg::ADDR_CONTROL_ZERO) begin
      c0_ff <= writedata[7:0];
    end else if (take && address == standard_timer_pkg::ADDR_CONTROL_ONE) begin
      c1_ff <= writedata[7:0];
    end
  end

  // ==========================================================
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Switch-on from the pin source in compare mode
  sequence on_rise_s;
    take && address == standard_timer_pkg::ADDR_CONTROL_ZERO && writedata[3] && !c0_ff[3]
      && writedata[6:5] == 2'h3 && c1_ff[7:6] == 2'h0;
  endsequence
  sequence forced_s;
    (c0_ff[3] && c1_ff[7:6] == 2'h2 && !c1_ff[5]) [*4];
  endsequence

  wait_once_a: assert property (!waitrequest |=> waitrequest)
    else $error("answer held longer than one cycle");
  answer_one_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered after one wait cycle");
  idle_wait_a: assert property (!read && !write |=> waitrequest)
    else $error("answer without request");
  read_upper_a: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  ctrl0_low_a: assert property (read && !waitrequest
    && address == standard_timer_pkg::ADDR_CONTROL_ZERO |-> readdata[2:0] == 3'h0)
    else $error("unused control bits not zero");
  unmapped_a: assert property (read && !waitrequest && address == 5'h1c |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  timer_pin_a: assert property ((c1_ff[7:6] == 2'h3) [*3] |-> !timer_output_used)
    else $error("pin used in timer mode");
  used_pin_a: assert property ((c1_ff[7:6] != 2'h3) [*3] |-> timer_output_used)
    else $error("pin unused outside timer mode");
  on_reload_a: assert property (on_rise_s |-> ##3 timer_output_pin == (c1_ff[3] ^ c1_ff[2]))
    else $error("pin not reloaded on switch-on");
  forced_level_a: assert property (forced_s
    |-> timer_output_pin == ((c1_ff[4] ? c1_ff[3] : !c1_ff[3]) ^ c1_ff[2]))
    else $error("forced pin level wrong");
endmodule : timer_unit_asserts

bind standard_timer_unit timer_unit_asserts u_chk (
  .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .timer_output_pin(timer_output_pin),
  .timer_output_used(timer_output_used)
);

// >>> sim/testbench.sv
// Testbench: registers, counter and output pin of the timer unit
`timescale 1ns/1ps
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin errors++; \
  $display("[ERR] %s expected %h seen %h", nm, e, s); end end

module testbench;
  localparam logic [4:0] C0 = standard_timer_pkg::ADDR_CONTROL_ZERO;
  localparam logic [4:0] C1 = standard_timer_pkg::ADDR_CONTROL_ONE;
  localparam logic [4:0] AL = standard_timer_pkg::ADDR_CMPA_LOW;
  localparam logic [4:0] AH = standard_timer_pkg::ADDR_CMPA_HIGH;
  logic        clk;
  logic        rst;
  logic [4:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        ext_pin;
  logic        sub_tick;
  logic        high_tick;
  logic        pin;
  logic        used;
  int          errors;
  int          comparisons;
  int          seed;
  logic [15:0] v;
  logic [7:0]  exp_q[$];
  string       what_q[$];
  logic [31:0] m_exp;
  string       m_what;
  logic [2:0]  srcs [6] = '{3'h6, 3'h7, 3'h4, 3'h5, 3'h2, 3'h3};
  int          sels [6] = '{0, 0, 1, 1, 2, 2};
  int          cnts [6] = '{3, 3, 3, 3, 48, 192};

  initial clk = 1'b0;
  always #2 clk = ~clk;

  standard_timer_unit u_dut (
    .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'h1), .readdata(readdata),
    .waitrequest(waitrequest), .high_clock_tick(high_tick), .sub_clock_tick(sub_tick),
    .external_clock_pin(ext_pin), .timer_output_pin(pin), .timer_output_used(used)
  );
  timer_pins_model u_pins (.clk(clk), .ext_pin(ext_pin), .sub_tick(sub_tick),
    .high_tick(high_tick));

  task automatic give_verdict();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  // ==========================================================
  // Bus master
  task automatic bus(input logic is_wr, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    address   <= a;
    writedata <= {24'h0, d};
    read      <= !is_wr;
    write     <= is_wr;
    @(posedge clk);
    while (waitrequest !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) begin
      errors++;
      give_verdict();
    end else begin
      read  <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
    end
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [7:0] e, input string nm);
    exp_q.push_back(e);
    what_q.push_back(nm);
    bus(1'b0, a, 8'h00);
  endtask : rd

  // High byte first so the low byte comes from the snapshot
  task automatic rdcnt(input logic [15:0] e);
    rd(standard_timer_pkg::ADDR_COUNT_HIGH, e[15:8], "cnt_hi");
    rd(standard_timer_pkg::ADDR_COUNT_LOW, e[7:0], "cnt_lo");
  endtask : rdcnt

  // ==========================================================
  // Read monitor
  always @(posedge clk) begin
    if (read && waitrequest === 1'b0) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("[ERR] readdata expected none seen %h", readdata);
      end else begin
        m_exp  = {24'h0, exp_q.pop_front()};
        m_what = what_q.pop_front();
        `CHK(m_what, m_exp, readdata)
      end
    end
  end

  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    give_verdict();
  end

  // ==========================================================
  // Main sequence
  initial begin
    seed = 32'h7fb9b264;
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 5'h00;
    writedata = 32'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 8; i++) rd(5'(i * 4), 8'h00, "reset");
    wr(C0, 8'hff);
    rd(C0, 8'hf8, "ctrl0");
    wr(standard_timer_pkg::ADDR_COUNT_HIGH, 8'h55);
    rdcnt(16'h0000);
    repeat (3) begin
      v = 16'($random(seed));
      wr(AL, v[7:0]);
      wr(AH, v[15:8]);
      wr(AL, ~v[7:0]);
      rd(AH, v[15:8], "cmpa_hi");
      rd(AL, v[7:0], "cmpa_lo");
    end
    wr(C0, 8'h60);
    wr(C0, 8'h68);
    u_pins.pulse(0, 4);
    rdcnt(16'd4);
    wr(C0, 8'he8);
    u_pins.pulse(0, 2);
    rdcnt(16'd4);
    wr(C0, 8'h68);
    u_pins.pulse(0, 1);
    rdcnt(16'd5);
    wr(C0, 8'h60);
    u_pins.pulse(0, 2);
    rdcnt(16'd5);
    wr(C0, 8'h68);
    rdcnt(16'd0);
    wr(C0, 8'h00);
    wr(C1, 8'hc0);
    repeat (3) @(posedge clk);
    `CHK("used", 1'b0, used)
    for (int i = 0; i < 6; i++) begin
      wr(C0, {1'b0, srcs[i], 4'h0});
      wr(C0, {1'b0, srcs[i], 4'h8});
      u_pins.pulse(sels[i], cnts[i]);
      rdcnt(16'd3);
    end
    wr(C0, 8'h10);
    wr(C0, 8'h18);
    wr(C0, 8'h98);
    rdcnt(16'd2);
    wr(standard_timer_pkg::ADDR_CMPP, 8'h01);
    wr(C0, 8'h40);
    wr(C0, 8'h48);
    u_pins.pulse(1, 258);
    rdcnt(16'd2);
    wr(AL, 8'h05);
    wr(AH, 8'h00);
    wr(C0, 8'h60);
    wr(C1, 8'hc1);
    wr(C0, 8'h68);
    u_pins.pulse(0, 7);
    rdcnt(16'd2);
    wr(C0, 8'h60);
    wr(AL, 8'h03);
    wr(AH, 8'h00);
    wr(C1, 8'h39);
    wr(C0, 8'h68);
    repeat (4) @(posedge clk);
    `CHK("pin", 1'b1, pin)
    u_pins.pulse(0, 3);
    `CHK("pin", 1'b0, pin)
    for (int k = 0; k < 8; k++) begin
      wr(C0, 8'h60);
      wr(C1, {2'h2, 1'b0, 3'(k), 2'h0});
      wr(C0, 8'h68);
      repeat (4) @(posedge clk);
      `CHK("pin", (k[2] ? k[1] : !k[1]) ^ k[0], pin)
    end
    wr(C0, 8'h40);
    wr(AL, 8'h02);
    wr(AH, 8'h00);
    wr(C1, 8'ha8);
    wr(C0, 8'h48);
    u_pins.pulse(1, 1);
    `CHK("pin", 1'b1, pin)
    u_pins.pulse(1, 1);
    `CHK("pin", 1'b0, pin)
    wr(C0, 8'h40);
    wr(AL, 8'h03);
    wr(AH, 8'h00);
    wr(C1, 8'hba);
    wr(C0, 8'h48);
    u_pins.pulse(1, 1);
    `CHK("pin", 1'b1, pin)
    u_pins.pulse(1, 2);
    `CHK("pin", 1'b0, pin)
    rdcnt(16'd0);
    wr(C0, 8'h60);
    wr(C1, 8'h40);
    repeat (3) @(posedge clk);
    `CHK("used", 1'b1, used)
    give_verdict();
  end
endmodule : testbench
